// file: inc/cfrs_defs.svh
// Command codes, field positions, reset values and timing counts of the
// converter fault-retry and status block.
// Assumes inclusion by bare name from the design files.
`ifndef CFRS_DEFS_SVH
`define CFRS_DEFS_SVH

// Command codes
`define CFRS_CMD_CLEAR_FAULTS 8'h03
`define CFRS_CMD_TON_RESP 8'h63
`define CFRS_CMD_TOFF_DELAY 8'h64
`define CFRS_CMD_TOFF_FALL 8'h65
`define CFRS_CMD_TOFF_MAX 8'h66
`define CFRS_CMD_STATUS 8'h78
`define CFRS_CMD_TIME_UNIT 8'hd2

// Fault response fields
`define CFRS_RESP_HI 7
`define CFRS_RESP_LO 6
`define CFRS_RETRY_HI 5
`define CFRS_RETRY_LO 3
`define CFRS_DELAY_HI 2
`define CFRS_DELAY_LO 0
`define CFRS_RETRY_NONE 3'h0
`define CFRS_RETRY_FOREVER 3'h7
// Output-voltage fault time unit field of the time-unit register, in ms
`define CFRS_UNIT_HI 7
`define CFRS_UNIT_LO 0

// Brief status byte bit positions
`define CFRS_ST_OFF 6
`define CFRS_ST_VOUT_OV 5
`define CFRS_ST_IOUT_OC 4
`define CFRS_ST_VIN_UV 3
`define CFRS_ST_TEMP 2
`define CFRS_ST_CML 1
`define CFRS_ST_OTHER 0

// Reset values
`define CFRS_RST_TON_RESP 8'h80
`define CFRS_RST_TIME 16'h0000
`define CFRS_RST_TIME_UNIT 16'h0001

// Timing: one millisecond at a 100 ns clock
`define CFRS_MS_TIME_NS 1000000
`define CFRS_CLK_PERIOD_NS 100
`define CFRS_CYCLES_PER_MS (`CFRS_MS_TIME_NS / `CFRS_CLK_PERIOD_NS)
`define CFRS_MS_SAT 24'hff_ffff

`endif

// file: inc/cfrs_pkg.sv
// Types of the converter fault-retry and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package cfrs_pkg;

  typedef enum logic [2:0] {
    cfrs_st_off = 3'h0,
    cfrs_st_start = 3'h1,
    cfrs_st_on = 3'h2,
    cfrs_st_run_dly = 3'h3,
    cfrs_st_retry_wait = 3'h4,
    cfrs_st_latched = 3'h5,
    cfrs_st_toff_dly = 3'h6,
    cfrs_st_fall = 3'h7
  } cfrs_state_t;

  typedef enum logic [1:0] {
    cfrs_resp_ignore = 2'h0,
    cfrs_resp_run_retry = 2'h1,
    cfrs_resp_dis_retry = 2'h2,
    cfrs_resp_dis_latch = 2'h3
  } cfrs_resp_t;

endpackage

// file: verif/cfrs_stage_model.sv
// Power stage model: soft start, optional failure to regulate, decay.
// Assumes the block's enable and ramp outputs on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cfrs_stage_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // From the block and bench
  input wire logic out_en_i,
  input wire logic ramp_down_i,
  input wire logic fail_i,
  // To the block
  output logic pgood_o,
  output logic ton_timeout_o,
  output logic vout_low_o
);
  logic [5:0] on_cnt_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_cnt_q <= 6'h00;
    end else if (!out_en_i) begin
      on_cnt_q <= 6'h00;
    end else if (on_cnt_q != 6'h3f) begin
      on_cnt_q <= on_cnt_q + 6'h01;
    end
  end
  // A failing stage never regulates
  assign pgood_o = out_en_i && !ramp_down_i && !fail_i && (on_cnt_q >= 6'h04);
  // One timeout pulse per attempt, so a held enable cannot re-trigger
  assign ton_timeout_o = out_en_i && fail_i && (on_cnt_q == 6'h14);
  assign vout_low_o = !out_en_i && !ramp_down_i;
endmodule
`default_nettype wire

// file: verif/cfrs_top_sva.sv
// Port-level checker for the fault-retry and status block.
// Assumes a bind onto cfrs_top; all signals are on mclk_i.
`timescale 1ns/100ps
`default_nettype none
module cfrs_top_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Command port
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] cmd_rdata_o,
  input wire logic cmd_rvalid_o,
  // Stage and events
  input wire logic run_req_i,
  input wire logic vout_low_i,
  input wire logic shutdown_fault_i,
  input wire logic vout_ov_i,
  input wire logic iout_oc_i,
  input wire logic vin_uv_i,
  input wire logic temp_i,
  input wire logic cml_i,
  input wire logic other_i,
  // Outputs
  input wire logic out_en_o,
  input wire logic ramp_down_o,
  input wire logic toff_warn_o,
  input wire logic fault_latched_o,
  input wire logic [2:0] attempts_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_wr_rd;
    cmd_wr_i ##1 !cmd_wr_i ##1 cmd_rd_i && !cmd_wr_i && cmd_code_i == $past(cmd_code_i, 2)
      && cmd_code_i inside {8'h64, 8'h65, 8'h66};
  endsequence
  property p_rd_ans;
    cmd_rd_i |=> cmd_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_rdback;
    s_wr_rd |=> cmd_rdata_o == $past(cmd_wdata_i, 3);
  endproperty
  a_rdback: assert property (p_rdback) else $error("time word not kept");
  property p_sticky;
    cmd_rd_i && cmd_code_i == 8'h78 |=> (cmd_rdata_o[5:0]
      | ~$past({vout_ov_i, iout_oc_i, vin_uv_i, temp_i, cml_i, other_i}, 2)) == 6'h3f;
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit lost");
  property p_off;
    cmd_rd_i && cmd_code_i == 8'h78 && !out_en_o && !$past(out_en_o) && !$past(out_en_o, 2)
      |=> cmd_rdata_o[6];
  endproperty
  a_off: assert property (p_off) else $error("off bit clear while off");
  property p_clr;
    cmd_wr_i && cmd_code_i == 8'h03 && fault_latched_o && !shutdown_fault_i
      |=> !fault_latched_o ##[0:1] attempts_o == 3'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not release");
  property p_offtog;
    fault_latched_o && !run_req_i && !shutdown_fault_i |=> !fault_latched_o;
  endproperty
  a_offtog: assert property (p_offtog) else $error("off request kept latch");
  property p_shut;
    out_en_o && !ramp_down_o && run_req_i && shutdown_fault_i |=> fault_latched_o && !out_en_o;
  endproperty
  a_shut: assert property (p_shut) else $error("forced shutdown missed");
  property p_warn;
    $rose(toff_warn_o) |-> !$past(vout_low_i);
  endproperty
  a_warn: assert property (p_warn) else $error("warning with output low");
  property p_latch_off;
    fault_latched_o |-> !out_en_o && !ramp_down_o;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for cfrs_top with a stage model and checker.
// Assumes a 1 ms tick of 10 cycles through CYCLES_PER_MS.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic wr; logic [7:0] c; logic [15:0] d; logic [15:0] e;} cfrs_row_t;
  cfrs_row_t rows [13] = '{'{0, 8'h63, 0, 16'h0080}, '{0, 8'h64, 0, 0}, '{0, 8'h65, 0, 0},
    '{0, 8'h66, 0, 0}, '{0, 8'hd2, 0, 16'h0001}, '{0, 8'h78, 0, 16'h0040}, '{0, 8'h10, 0, 0},
    '{1, 8'h64, 16'h0003, 16'h0003}, '{1, 8'h65, 16'h0002, 16'h0002},
    '{1, 8'h66, 16'h0001, 16'h0001}, '{1, 8'hd2, 16'h0002, 16'h0002},
    '{1, 8'h78, 16'hffff, 16'h0040}, '{1, 8'h63, 16'h00c5, 16'h00c5}};
  logic [2:0] dc [4] = '{3'h0, 3'h3, 3'h1, 3'h7};
  logic [7:0] du [4] = '{8'h01, 8'h01, 8'h03, 8'h01};
  logic mclk_i = 0, arst_n_i = 0, cmd_wr_i = 0, cmd_rd_i = 0, run_req_i = 0;
  logic shutdown_fault_i = 0, fail = 0;
  logic [7:0] cmd_code_i = 0;
  logic [15:0] cmd_wdata_i = 0;
  logic [5:0] ev = 0;
  logic [15:0] cmd_rdata_o;
  logic cmd_rvalid_o, out_en_o, ramp_down_o, toff_warn_o, fault_latched_o;
  logic pgood_i, ton_timeout_i, vout_low_i;
  logic [2:0] attempts_o;
  int miscompares = 0, checked = 0, cyc = 0, n, g, ms;
  always #50 mclk_i = ~mclk_i;
  cfrs_top #(.CYCLES_PER_MS(10)) cfrs_top_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .cmd_code_i(cmd_code_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
    .run_req_i(run_req_i), .pgood_i(pgood_i), .ton_timeout_i(ton_timeout_i),
    .vout_low_i(vout_low_i), .shutdown_fault_i(shutdown_fault_i), .vout_ov_i(ev[5]),
    .iout_oc_i(ev[4]), .vin_uv_i(ev[3]), .temp_i(ev[2]), .cml_i(ev[1]), .other_i(ev[0]),
    .out_en_o(out_en_o), .ramp_down_o(ramp_down_o), .toff_warn_o(toff_warn_o),
    .fault_latched_o(fault_latched_o), .attempts_o(attempts_o));
  cfrs_stage_model cfrs_stage_model_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .out_en_i(out_en_o), .ramp_down_i(ramp_down_o), .fail_i(fail), .pgood_o(pgood_i),
    .ton_timeout_o(ton_timeout_i), .vout_low_o(vout_low_i));
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk_i) cmd_code_i <= c;
    cmd_wdata_i <= d;
    cmd_wr_i <= 1'b1;
    @(posedge mclk_i) cmd_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e);
    @(posedge mclk_i) cmd_code_i <= c;
    cmd_rd_i <= 1'b1;
    @(posedge mclk_i) cmd_rd_i <= 1'b0;
    #1;
    chk("rvalid", {15'h0, cmd_rvalid_o}, 16'h0001);
    chk("rdata", cmd_rdata_o, e);
  endtask
  function automatic logic sig(int w);
    return w == 0 ? out_en_o : (w == 1 ? ramp_down_o : fault_latched_o);
  endfunction
  task wait_sig(input int w, input logic v, output int k);
    k = 0;
    while (sig(w) !== v && k < 3000) begin
      @(posedge mclk_i) #1;
      k++;
    end
  endtask
  // Counts enable rises, so restarts are judged at the stage pin
  task run_until(input int lim, output int k);
    logic p;
    k = 0;
    p = out_en_o;
    repeat (lim) begin
      @(posedge mclk_i) #1;
      if (out_en_o === 1'b1 && p !== 1'b1) k++;
      p = out_en_o;
      if (fault_latched_o === 1'b1) break;
    end
  endtask
  // Long enough for the whole delay and fall sequence to finish
  task off;
    @(posedge mclk_i) run_req_i <= 1'b0;
    repeat (80) @(posedge mclk_i);
  endtask
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].c, rows[i].d);
      rd(rows[i].c, rows[i].e);
    end
    $display("register test done");
    fail <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      wr(8'h63, {8'h00, 2'b10, r[2:0], 3'h0});
      @(posedge mclk_i) run_req_i <= 1'b1;
      run_until(1500, n);
      chk("restarts", 16'(n), 16'(r + 1));
      chk("attempts", {13'h0, attempts_o}, 16'(r));
      if (r[0]) @(posedge mclk_i) run_req_i <= 1'b0;
      else wr(8'h03, 16'h0000);
      repeat (2) @(posedge mclk_i) #1;
      chk("latch clear", {15'h0, fault_latched_o}, 16'h0000);
      chk("count clear", {13'h0, attempts_o}, 16'h0000);
      off;
    end
    wr(8'h63, 16'h00b8);
    @(posedge mclk_i) run_req_i <= 1'b1;
    run_until(700, n);
    chk("endless", {15'h0, fault_latched_o}, 16'h0000);
    chk("saturate", {13'h0, attempts_o}, 16'h0007);
    wait_sig(0, 1'b1, n);
    @(posedge mclk_i) shutdown_fault_i <= 1'b1;
    @(posedge mclk_i) shutdown_fault_i <= 1'b0;
    #1;
    chk("shutdown", {15'h0, fault_latched_o}, 16'h0001);
    off;
    $display("retry test done");
    for (int rp = 0; rp < 4; rp++) begin
      wr(8'h63, {8'h00, rp[1:0], (rp == 3) ? 3'h7 : 3'h0, 3'h0});
      @(posedge mclk_i) run_req_i <= 1'b1;
      run_until(200, n);
      chk("response", {15'h0, fault_latched_o}, 16'(rp != 0));
      off;
    end
    $display("response test done");
    foreach (dc[i]) begin
      wr(8'hd2, {8'h00, du[i]});
      wr(8'h63, {8'h00, 2'b10, 3'h1, dc[i]});
      @(posedge mclk_i) run_req_i <= 1'b1;
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, n);
      wait_sig(0, 1'b1, g);
      ms = (1 << dc[i]) * du[i];
      chk("gap", 16'(g >= (ms - 1) * 10 && g <= (ms + 1) * 10 + 3), 16'h0001);
      off;
    end
    $display("delay test done");
    @(posedge mclk_i) fail <= 1'b0;
    run_req_i <= 1'b1;
    wait_sig(0, 1'b1, n);
    repeat (20) @(posedge mclk_i);
    wr(8'h03, 16'h0000);
    rd(8'h78, 16'h0000);
    for (int b = 0; b < 6; b++) begin
      @(posedge mclk_i) ev <= 6'(1 << b);
      @(posedge mclk_i) ev <= 6'h00;
      rd(8'h78, 16'(1 << b));
      wr(8'h78, 16'(1 << b));
      rd(8'h78, 16'h0000);
    end
    $display("status test done");
    @(posedge mclk_i) run_req_i <= 1'b0;
    wait_sig(1, 1'b1, n);
    chk("off delay", 16'(n >= 20 && n <= 44), 16'h0001);
    wait_sig(1, 1'b0, n);
    chk("fall time", 16'(n >= 10 && n <= 33), 16'h0001);
    chk("warning", {15'h0, toff_warn_o}, 16'h0001);
    rd(8'h78, 16'h0041);
    wr(8'h03, 16'h0000);
    #1;
    chk("warning clear", {15'h0, toff_warn_o}, 16'h0000);
    $display("turn-off test done");
    @(posedge mclk_i) arst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd(8'h63, 16'h0080);
    chk("reset enable", {15'h0, out_en_o}, 16'h0000);
    $display("reset test done");
    summarize();
  end
endmodule
bind cfrs_top cfrs_top_sva cfrs_top_sva_inst (.*);
`default_nettype wire

// file: verilog/cfrs_lin2ms.sv
// Linear-format (5-bit exponent, 11-bit mantissa) to whole milliseconds.
// Assumes a same-clock source; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "cfrs_defs.svh"
module cfrs_lin2ms (
  // Linear value and result
  input wire logic [15:0] lin_i,
  output logic [23:0] ms_o
);
  logic [4:0] rshift;
  logic [23:0] mant;

  always_comb begin
    rshift = 5'(~lin_i[15:11] + 5'h01);
    mant = {14'h0000, lin_i[9:0]};
    ms_o = 24'h00_0000;
    // Negative times make no sense here and read as zero
    if (!lin_i[10]) begin
      if (!lin_i[15]) begin
        if (lin_i[14:11] > 4'hd) begin
          ms_o = `CFRS_MS_SAT;
        end else begin
          ms_o = mant << lin_i[14:11];
        end
      end else begin
        ms_o = mant >> rshift;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/cfrs_ms_timer.sv
// Millisecond down-counter driven by a shared one-cycle millisecond tick.
// Assumes the tick comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cfrs_ms_timer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [23:0] len_ms_i,
  // Result
  output logic done_o
);
  logic [23:0] cnt_q;
  logic busy_q;

  // Resolution is one tick: done comes one tick after zero, so the length may run long by up to 1 ms
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 24'h00_0000;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= len_ms_i;
        busy_q <= 1'b1;
      end else if (busy_q && tick_i) begin
        if (cnt_q == 24'h00_0000) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h00_0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/cfrs_top.sv
// Turn-on timeout fault response with restart retries, turn-off delay and
// fall sequencing, turn-off time warning and the brief fault status byte.
// Assumes all inputs come from logic on mclk_i; command port is the
// device-side end of the host command decoder.
// Functional notes
// - Retry codes 4, 5, 6 give that many restarts, then latch off.
// - Code 7 retries forever until off command or other fault.
// - Restart attempts are spaced by delay field times time unit.
// - Delay field code n selects two to the n time units.
// - Same delay times keep-running response and gap between restarts.
// - Time unit length comes from the time-unit register.
// - Turn-on timeout uses the output-voltage fault time unit.
// - Turn-off delay register, linear ms, waits before ramp-down starts.
// - Fall time register, linear ms, sets ramp-down length.
// - Turn-off limit register; slow fall to 12.5% raises warning.
// - Status bit 6 set whenever output delivers no power.
// - Status bits 5, 4, 3 flag overvoltage, overcurrent, input undervoltage.
// - Status bit 2 flags any temperature fault or warning.
// - Status bit 1 flags communication, memory or logic fault.
// - Status bit 0 flags any other fault or warning.
// - Response 00 ignore, 01 run then retry, 10 disable retry, 11 latch.
// - Code 0 never restarts; 1 to 3 restart that often, then latch.
// - Latched fault clears by clear command, reset, off toggle.
`timescale 1ns/100ps
`default_nettype none
`include "cfrs_defs.svh"
module cfrs_top #(
  parameter int unsigned CYCLES_PER_MS = `CFRS_CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Command port
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  // Power stage control and feedback
  input wire logic run_req_i,
  input wire logic pgood_i,
  input wire logic ton_timeout_i,
  input wire logic vout_low_i,
  input wire logic shutdown_fault_i,
  // Fault events
  input wire logic vout_ov_i,
  input wire logic iout_oc_i,
  input wire logic vin_uv_i,
  input wire logic temp_i,
  input wire logic cml_i,
  input wire logic other_i,
  // Outputs
  output logic out_en_o,
  output logic ramp_down_o,
  output logic toff_warn_o,
  output logic fault_latched_o,
  output logic [2:0] attempts_o
);
  import cfrs_pkg::*;

  cfrs_state_t state_q, state_d;
  cfrs_resp_t resp;
  logic [7:0] ton_resp_q, delay_units, unit_ms;
  logic [15:0] toff_dly_q, toff_fall_q, toff_max_q, time_unit_q;
  logic [23:0] presc_q, seq_len, retry_ms, toff_dly_ms, toff_fall_ms, toff_max_ms;
  logic [5:0] sticky_q, events;
  logic [2:0] att_d, retries;
  logic ms_tick_q, off_q, warn_arm_q, clear_cmd, retry_ok;
  logic seq_start, seq_done, warn_done, toff_start;

  assign clear_cmd = cmd_wr_i && (cmd_code_i == `CFRS_CMD_CLEAR_FAULTS);
  assign resp = cfrs_resp_t'(ton_resp_q[`CFRS_RESP_HI:`CFRS_RESP_LO]);
  assign retries = ton_resp_q[`CFRS_RETRY_HI:`CFRS_RETRY_LO];

  assign delay_units = 8'h01 << ton_resp_q[`CFRS_DELAY_HI:`CFRS_DELAY_LO];
  assign unit_ms = (time_unit_q[`CFRS_UNIT_HI:`CFRS_UNIT_LO] == 8'h00) ? 8'h01 :
    time_unit_q[`CFRS_UNIT_HI:`CFRS_UNIT_LO];
  assign retry_ms = {8'h00, 16'(delay_units) * 16'(unit_ms)};

  assign retry_ok = (retries == `CFRS_RETRY_FOREVER) ||
    ((retries != `CFRS_RETRY_NONE) && (attempts_o < retries));

  cfrs_lin2ms u_dly (.lin_i(toff_dly_q), .ms_o(toff_dly_ms));
  cfrs_lin2ms u_fall (.lin_i(toff_fall_q), .ms_o(toff_fall_ms));
  cfrs_lin2ms u_max (.lin_i(toff_max_q), .ms_o(toff_max_ms));

  cfrs_ms_timer u_seq_tmr (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(seq_start),
    .tick_i(ms_tick_q), .len_ms_i(seq_len), .done_o(seq_done));
  cfrs_ms_timer u_warn_tmr (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(toff_start),
    .tick_i(ms_tick_q), .len_ms_i(toff_max_ms), .done_o(warn_done));

  // Millisecond tick shared by both timers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_q <= 24'h00_0000;
      ms_tick_q <= 1'b0;
    end else if (presc_q == 24'(CYCLES_PER_MS - 1)) begin
      presc_q <= 24'h00_0000;
      ms_tick_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 24'h00_0001;
      ms_tick_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    att_d = attempts_o;
    seq_start = 1'b0;
    seq_len = retry_ms;
    toff_start = 1'b0;
    case (state_q)
      cfrs_st_off: begin
        if (run_req_i && !shutdown_fault_i) begin
          state_d = cfrs_st_start;
        end
      end
      cfrs_st_start: begin
        if (!run_req_i) begin
          state_d = cfrs_st_off;
          att_d = 3'h0;
        end else if (shutdown_fault_i) begin
          state_d = cfrs_st_latched;
        end else if (pgood_i) begin
          state_d = cfrs_st_on;
          att_d = 3'h0;
        end else if (ton_timeout_i) begin
          case (resp)
            cfrs_resp_ignore: begin
              state_d = cfrs_st_start;
            end
            cfrs_resp_run_retry: begin
              state_d = cfrs_st_run_dly;
              seq_start = 1'b1;
            end
            cfrs_resp_dis_retry: begin
              state_d = retry_ok ? cfrs_st_retry_wait : cfrs_st_latched;
              seq_start = retry_ok;
            end
            default: begin
              state_d = cfrs_st_latched;
            end
          endcase
        end
      end
      cfrs_st_run_dly: begin
        if (!run_req_i) begin
          state_d = cfrs_st_toff_dly;
          seq_start = 1'b1;
          seq_len = toff_dly_ms;
          toff_start = 1'b1;
        end else if (shutdown_fault_i) begin
          state_d = cfrs_st_latched;
        end else if (seq_done) begin
          // Run delay over: power good resumes on, else retry or latch
          if (pgood_i) begin
            state_d = cfrs_st_on;
            att_d = 3'h0;
          end else begin
            state_d = retry_ok ? cfrs_st_retry_wait : cfrs_st_latched;
            seq_start = retry_ok;
          end
        end
      end
      cfrs_st_retry_wait: begin
        // Off command or other fault ends retrying
        if (!run_req_i) begin
          state_d = cfrs_st_off;
          att_d = 3'h0;
        end else if (shutdown_fault_i) begin
          state_d = cfrs_st_latched;
        end else if (seq_done) begin
          state_d = cfrs_st_start;
          att_d = (attempts_o == 3'h7) ? 3'h7 : attempts_o + 3'h1;
        end
      end
      cfrs_st_on: begin
        if (!run_req_i) begin
          state_d = cfrs_st_toff_dly;
          seq_start = 1'b1;
          seq_len = toff_dly_ms;
          toff_start = 1'b1;
        end else if (shutdown_fault_i) begin
          state_d = cfrs_st_latched;
        end
      end
      cfrs_st_toff_dly: begin
        if (shutdown_fault_i) begin
          state_d = cfrs_st_latched;
        end else if (seq_done) begin
          state_d = cfrs_st_fall;
          seq_start = 1'b1;
          seq_len = toff_fall_ms;
        end
      end
      cfrs_st_fall: begin
        if (seq_done || shutdown_fault_i) begin
          state_d = cfrs_st_off;
        end
      end
      default: begin
        // Clear by command or off toggle
        if (clear_cmd || !run_req_i) begin
          state_d = cfrs_st_off;
          att_d = 3'h0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= cfrs_st_off;
      attempts_o <= 3'h0;
      out_en_o <= 1'b0;
      ramp_down_o <= 1'b0;
      fault_latched_o <= 1'b0;
      off_q <= 1'b1;
    end else begin
      state_q <= state_d;
      attempts_o <= att_d;
      out_en_o <= (state_d == cfrs_st_start) || (state_d == cfrs_st_on) ||
        (state_d == cfrs_st_run_dly) || (state_d == cfrs_st_toff_dly) ||
        (state_d == cfrs_st_fall);
      ramp_down_o <= (state_d == cfrs_st_fall);
      fault_latched_o <= (state_d == cfrs_st_latched);
      off_q <= !((state_d == cfrs_st_on) || (state_d == cfrs_st_run_dly) ||
        (state_d == cfrs_st_toff_dly));
    end
  end

  // Turn-off time warning; a zero limit disables the check
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warn_arm_q <= 1'b0;
      toff_warn_o <= 1'b0;
    end else begin
      if (toff_start) begin
        warn_arm_q <= (toff_max_ms != 24'h00_0000);
      end else if (vout_low_i || warn_done) begin
        warn_arm_q <= 1'b0;
      end
      if (warn_arm_q && warn_done && !vout_low_i) begin
        toff_warn_o <= 1'b1;
      end else if (clear_cmd) begin
        toff_warn_o <= 1'b0;
      end
    end
  end

  assign events = {vout_ov_i, iout_oc_i, vin_uv_i, temp_i, cml_i,
    other_i || ton_timeout_i || (warn_arm_q && warn_done && !vout_low_i)};

  // Sticky status: a new event wins over a clear in the same cycle
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sticky
      always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sticky_q[i] <= 1'b0;
        end else if (events[i]) begin
          sticky_q[i] <= 1'b1;
        end else if (clear_cmd ||
          (cmd_wr_i && (cmd_code_i == `CFRS_CMD_STATUS) && cmd_wdata_i[i])) begin
          sticky_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Configuration writes; writes to unknown or read-only codes are dropped
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ton_resp_q <= `CFRS_RST_TON_RESP;
      toff_dly_q <= `CFRS_RST_TIME;
      toff_fall_q <= `CFRS_RST_TIME;
      toff_max_q <= `CFRS_RST_TIME;
      time_unit_q <= `CFRS_RST_TIME_UNIT;
    end else if (cmd_wr_i) begin
      if (cmd_code_i == `CFRS_CMD_TON_RESP) begin
        ton_resp_q <= cmd_wdata_i[7:0];
      end else if (cmd_code_i == `CFRS_CMD_TOFF_DELAY) begin
        toff_dly_q <= cmd_wdata_i;
      end else if (cmd_code_i == `CFRS_CMD_TOFF_FALL) begin
        toff_fall_q <= cmd_wdata_i;
      end else if (cmd_code_i == `CFRS_CMD_TOFF_MAX) begin
        toff_max_q <= cmd_wdata_i;
      end else if (cmd_code_i == `CFRS_CMD_TIME_UNIT) begin
        time_unit_q <= cmd_wdata_i;
      end
    end
  end

  // Reads answer one cycle later; unknown codes read zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_rdata_o <= 16'h0000;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_rd_i;
      if (cmd_rd_i) begin
        if (cmd_code_i == `CFRS_CMD_TON_RESP) begin
          cmd_rdata_o <= {8'h00, ton_resp_q};
        end else if (cmd_code_i == `CFRS_CMD_TOFF_DELAY) begin
          cmd_rdata_o <= toff_dly_q;
        end else if (cmd_code_i == `CFRS_CMD_TOFF_FALL) begin
          cmd_rdata_o <= toff_fall_q;
        end else if (cmd_code_i == `CFRS_CMD_TOFF_MAX) begin
          cmd_rdata_o <= toff_max_q;
        end else if (cmd_code_i == `CFRS_CMD_TIME_UNIT) begin
          cmd_rdata_o <= time_unit_q;
        end else if (cmd_code_i == `CFRS_CMD_STATUS) begin
          cmd_rdata_o <= {8'h00, 1'b0, off_q, sticky_q};
        end else begin
          cmd_rdata_o <= 16'h0000;
        end
      end
    end
  end
endmodule
`default_nettype wire
